// ---- irt_pkg.sv ----
// Purpose: Shared constants and types for the ingress rate table access block.
// Assumes: 32-bit Avalon-MM register bus, one register per aligned word.
// Notes:   Register indices are kept as printed; byte address is four times the index.
package irt_pkg;

  // ----------------------------------------------------------------
  // Bus and data widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned ENTRY_W = 16;
  localparam int unsigned CMD_W = 8;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_CFG = 16'h184a;
  localparam logic [ADDR_W-1:0] IDX_CMD = 16'h184b;
  localparam logic [ADDR_W-1:0] IDX_STS = 16'h184c;
  localparam logic [ADDR_W-1:0] IDX_WDATA = 16'h184d;
  localparam logic [ADDR_W-1:0] IDX_RDATA = 16'h184e;
  localparam logic [ADDR_W-1:0] ADR_CFG = {IDX_CFG[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_CMD = {IDX_CMD[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_STS = {IDX_STS[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_WDATA = {IDX_WDATA[ADDR_W-3:0], 2'b00};
  localparam logic [ADDR_W-1:0] ADR_RDATA = {IDX_RDATA[ADDR_W-3:0], 2'b00};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CMD_RNW_BIT = 7;
  localparam int unsigned CMD_TYPE_HI = 6;
  localparam int unsigned CMD_TYPE_LO = 5;
  localparam int unsigned CMD_IDX_HI = 4;
  localparam int unsigned CMD_IDX_LO = 0;
  localparam int unsigned CFG_EN_BIT = 0;
  localparam int unsigned CFG_MODE_HI = 2;
  localparam int unsigned CFG_MODE_LO = 1;
  localparam int unsigned STS_PEND_BIT = 0;

  // ----------------------------------------------------------------
  // Table types and metering modes
  // ----------------------------------------------------------------
  localparam logic [1:0] TBL_RSVD = 2'h0;
  localparam logic [1:0] TBL_CIR = 2'h1;
  localparam logic [1:0] TBL_CBS = 2'h2;
  localparam logic [1:0] TBL_EBS = 2'h3;
  localparam logic [1:0] MODE_PORT_PRIO = 2'h0;
  localparam logic [1:0] MODE_PORT = 2'h1;
  localparam logic [1:0] MODE_PRIO = 2'h2;

  // ----------------------------------------------------------------
  // Table geometry, reset values, timing
  // ----------------------------------------------------------------
  localparam int unsigned CIR_COUNT = 24;
  localparam int unsigned CIR_IDX_W = 5;
  localparam int unsigned PORT_COUNT = 3;
  localparam int unsigned PRIO_PER_PORT = 8;
  localparam logic [ENTRY_W-1:0] RST_BURST = 16'h0600;
  localparam logic [ENTRY_W-1:0] RST_CIR = 16'h0014;
  localparam logic [ENTRY_W-1:0] RST_DATA = 16'h0000;
  localparam logic [CMD_W-1:0] RST_CMD = 8'h00;
  localparam int unsigned BYTE_TIME_W = 22;
  localparam logic [BYTE_TIME_W-1:0] BYTE_TIME_UNIT_NS = 22'h000014;
  localparam logic [BYTE_TIME_W-1:0] BYTE_TIME_OFFSET = 22'h000001;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_FINISH} irt_state_type;

endpackage

// ---- irt_table.sv ----
// Purpose: Storage for the committed-rate entries and the two burst sizes.
// Assumes: One access port from the command engine, one lookup port for metering.
// Notes:   Read data and lookup data are registered, one cycle after the request.
`timescale 1ns/100ps
module irt_table import irt_pkg::*; #(
  parameter int unsigned ENTRIES = CIR_COUNT,
  parameter int unsigned IW = CIR_IDX_W,
  parameter int unsigned W = ENTRY_W
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Command engine access
  input wire logic acc_we_i,
  input wire logic [1:0] acc_sel_i,
  input wire logic [IW-1:0] acc_idx_i,
  input wire logic [W-1:0] acc_wdata_i,
  output logic [W-1:0] acc_rdata_o,
  // Metering lookup
  input wire logic [IW-1:0] look_idx_i,
  input wire logic look_valid_i,
  output logic [W-1:0] look_rate_o,
  // Burst sizes
  output logic [W-1:0] cbs_o,
  output logic [W-1:0] ebs_o
);

  logic [W-1:0] committed_rate_entry [ENTRIES];
  logic [W-1:0] cir_rd;
  logic [W-1:0] look_rd;
  logic [W-1:0] next_rdata;
  logic acc_in_range;
  logic look_in_range;

  // ----------------------------------------------------------------
  // Entries
  // ----------------------------------------------------------------
  // Out-of-range indices touch nothing and read as zero
  assign acc_in_range = 32'(acc_idx_i) < ENTRIES;
  assign look_in_range = look_valid_i && (32'(look_idx_i) < ENTRIES);

  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_cir
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          committed_rate_entry[gi] <= RST_CIR;
        end else if (acc_we_i && acc_sel_i == TBL_CIR && 32'(acc_idx_i) == gi) begin
          committed_rate_entry[gi] <= acc_wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cbs_o <= RST_BURST;
      ebs_o <= RST_BURST;
    end else if (acc_we_i && acc_sel_i == TBL_CBS) begin
      cbs_o <= acc_wdata_i;
    end else if (acc_we_i && acc_sel_i == TBL_EBS) begin
      ebs_o <= acc_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Read paths
  // ----------------------------------------------------------------
  assign cir_rd = acc_in_range ? committed_rate_entry[acc_idx_i] : RST_DATA;
  assign look_rd = look_in_range ? committed_rate_entry[look_idx_i] : RST_DATA;
  // Reserved type reads as zero
  assign next_rdata = (acc_sel_i == TBL_CIR) ? cir_rd :
                      (acc_sel_i == TBL_CBS) ? cbs_o :
                      (acc_sel_i == TBL_EBS) ? ebs_o : RST_DATA;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      acc_rdata_o <= RST_DATA;
      look_rate_o <= RST_DATA;
    end else begin
      acc_rdata_o <= next_rdata;
      look_rate_o <= look_rd;
    end
  end

endmodule

// ---- irt_access.sv ----
// Purpose: Indirect command port and metering parameter table for ingress rate control.
// Assumes: Avalon-MM slave with waitrequest; meter inputs come from the same clock.
// Notes:   Each bus access takes two cycles; a table command stays pending two cycles.
`timescale 1ns/100ps

// What this block does
// - every command register write with byte lane 0 enabled launches one table access with its fields.
// - command bit 7 is direction, one reads, zero writes, resets zero.
// - command bits 6:5 pick rate table, committed burst, excess burst; 00 reserved.
// - command bits 4:0 index one of 24 committed-rate entries, reset zero.
// - port-and-priority mode maps port times eight plus priority to index.
// - port-only mode uses indices zero to two for ports zero to two.
// - priority-only mode uses the priority number as index, up to 23.
// - excess burst size in bytes resets to 0600h, drop beyond it.
// - committed burst size in bytes resets to 0600h, random discard beyond.
// - buckets start at default; smaller size limits only once drained to it.
// - rate entry means (value plus one) times 20 ns per byte; resets 0014h.
// - all table entries are sixteen bits, reached only by indirect commands.
// - status bit 0 pending is high while a command runs, resets zero.
// - config bits 2:1 pick port-and-priority, port-only, priority-only, reserved.
// - write staging bits 15:0 give the value a write command stores.
// - read staging bits 15:0 show the value the last read command fetched.
module irt_access import irt_pkg::*; #(
  parameter int unsigned ENTRIES = CIR_COUNT
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [BE_W-1:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Metering lookup
  input wire logic [1:0] meter_port_i,
  input wire logic [CIR_IDX_W-1:0] meter_prio_i,
  output logic [ENTRY_W-1:0] meter_rate_o,
  output logic [BYTE_TIME_W-1:0] meter_byte_time_ns_o,
  output logic meter_index_valid_o,
  output logic meter_enable_o,
  output logic [1:0] meter_mode_o,
  // Burst sizes and bucket ceilings
  input wire logic [ENTRY_W-1:0] committed_level_i,
  input wire logic [ENTRY_W-1:0] excess_level_i,
  output logic [ENTRY_W-1:0] committed_burst_o,
  output logic [ENTRY_W-1:0] excess_burst_o,
  output logic [ENTRY_W-1:0] committed_limit_o,
  output logic [ENTRY_W-1:0] excess_limit_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Byte-lane merge for the low sixteen bits of a register
  function automatic logic [ENTRY_W-1:0] merge16(input logic [ENTRY_W-1:0] old_v,
                                                 input logic [DATA_W-1:0] new_v,
                                                 input logic [BE_W-1:0] be);
    logic [ENTRY_W-1:0] r;
    r = old_v;
    if (be[0]) begin
      r[7:0] = new_v[7:0];
    end
    if (be[1]) begin
      r[15:8] = new_v[15:8];
    end
    return r;
  endfunction

  // Maps a port and priority to a committed-rate index under a metering mode
  function automatic logic [CIR_IDX_W:0] map_index(input logic [1:0] mode,
                                                   input logic [1:0] port,
                                                   input logic [CIR_IDX_W-1:0] prio);
    logic [CIR_IDX_W:0] r;
    logic [CIR_IDX_W-1:0] base;
    r = '0;
    base = CIR_IDX_W'(32'(port) * PRIO_PER_PORT);
    if (mode == MODE_PORT_PRIO) begin
      r[CIR_IDX_W] = (32'(port) < PORT_COUNT) && (32'(prio) < PRIO_PER_PORT);
      r[CIR_IDX_W-1:0] = base + prio;
    end else if (mode == MODE_PORT) begin
      r[CIR_IDX_W] = 32'(port) < PORT_COUNT;
      r[CIR_IDX_W-1:0] = CIR_IDX_W'(port);
    end else if (mode == MODE_PRIO) begin
      r[CIR_IDX_W] = 32'(prio) < ENTRIES;
      r[CIR_IDX_W-1:0] = prio;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic meter_en;
  logic [1:0] meter_mode;
  logic [CMD_W-1:0] cmd;
  logic [ENTRY_W-1:0] wr_staging;
  logic [ENTRY_W-1:0] rd_staging;
  logic pending;
  irt_state_type state;
  irt_state_type next_state;

  logic hit_cfg;
  logic hit_cmd;
  logic hit_sts;
  logic hit_wdata;
  logic hit_rdata;
  logic accept;
  logic wr_commit;
  logic launch;
  logic [DATA_W-1:0] next_readdata;
  logic [ENTRY_W-1:0] next_cfg;
  logic [ENTRY_W-1:0] next_cmd;
  logic [ENTRY_W-1:0] next_wdata;

  logic cmd_rnw;
  logic [1:0] cmd_type;
  logic [CIR_IDX_W-1:0] cmd_idx;
  logic table_we;
  logic [ENTRY_W-1:0] table_rdata;
  logic [CIR_IDX_W:0] look_map;
  logic [ENTRY_W-1:0] look_rate;
  logic [ENTRY_W-1:0] cbs;
  logic [ENTRY_W-1:0] ebs;
  logic look_valid_q;
  logic [BYTE_TIME_W-1:0] next_byte_time;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign hit_cfg = avs_address_i == ADR_CFG;
  assign hit_cmd = avs_address_i == ADR_CMD;
  assign hit_sts = avs_address_i == ADR_STS;
  assign hit_wdata = avs_address_i == ADR_WDATA;
  assign hit_rdata = avs_address_i == ADR_RDATA;

  // A request is accepted while waitrequest is high, and completes in the next cycle
  // with waitrequest low; that fixed two-cycle answer keeps the slave free of stalls.
  assign accept = (avs_read_i || avs_write_i) && avs_waitrequest_o;
  assign wr_commit = avs_write_i && !avs_waitrequest_o;
  assign launch = wr_commit && hit_cmd && avs_byteenable_i[0];

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  // Unmapped addresses and reserved bits read as zero
  always_comb begin
    next_readdata = '0;
    if (hit_cfg) begin
      next_readdata[CFG_EN_BIT] = meter_en;
      next_readdata[CFG_MODE_HI:CFG_MODE_LO] = meter_mode;
    end else if (hit_cmd) begin
      next_readdata[CMD_W-1:0] = cmd;
    end else if (hit_sts) begin
      next_readdata[STS_PEND_BIT] = pending;
    end else if (hit_wdata) begin
      next_readdata[ENTRY_W-1:0] = wr_staging;
    end else if (hit_rdata) begin
      next_readdata[ENTRY_W-1:0] = rd_staging;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= '0;
    end else begin
      avs_waitrequest_o <= !accept;
      if (accept) begin
        avs_readdata_o <= next_readdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  assign next_cfg = merge16({13'h0000, meter_mode, meter_en}, avs_writedata_i, avs_byteenable_i);
  assign next_cmd = merge16({8'h00, cmd}, avs_writedata_i, avs_byteenable_i);
  assign next_wdata = merge16(wr_staging, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meter_en <= 1'b0;
      meter_mode <= MODE_PORT_PRIO;
      cmd <= RST_CMD;
      wr_staging <= RST_DATA;
    end else if (wr_commit) begin
      if (hit_cfg) begin
        meter_en <= next_cfg[CFG_EN_BIT];
        meter_mode <= next_cfg[CFG_MODE_HI:CFG_MODE_LO];
      end
      if (hit_cmd) begin
        cmd <= next_cmd[CMD_W-1:0];
      end
      if (hit_wdata) begin
        wr_staging <= next_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command fields
  // ----------------------------------------------------------------
  assign cmd_rnw = cmd[CMD_RNW_BIT];
  assign cmd_type = cmd[CMD_TYPE_HI:CMD_TYPE_LO];
  assign cmd_idx = cmd[CMD_IDX_HI:CMD_IDX_LO];

  // Reserved type never raises the write strobe
  assign table_we = (state == ST_ACCESS) && !cmd_rnw && (cmd_type != TBL_RSVD);

  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  // A new command restarts the engine even mid-run; the later command wins.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        next_state = ST_IDLE;
      end
      ST_ACCESS: begin
        next_state = ST_FINISH;
      end
      ST_FINISH: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (launch) begin
      next_state = ST_ACCESS;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Set by a launch wins over the clear at completion
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pending <= 1'b0;
    end else if (launch) begin
      pending <= 1'b1;
    end else if (state == ST_FINISH) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rd_staging <= RST_DATA;
    end else if (state == ST_FINISH && cmd_rnw) begin
      rd_staging <= table_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Table storage
  // ----------------------------------------------------------------
  // Entries are written only through the access port below; the lookup port reads them
  irt_table #(
    .ENTRIES(ENTRIES),
    .IW(CIR_IDX_W),
    .W(ENTRY_W)
  ) u_table (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .acc_we_i(table_we),
    .acc_sel_i(cmd_type),
    .acc_idx_i(cmd_idx),
    .acc_wdata_i(wr_staging),
    .acc_rdata_o(table_rdata),
    .look_idx_i(look_map[CIR_IDX_W-1:0]),
    .look_valid_i(look_map[CIR_IDX_W]),
    .look_rate_o(look_rate),
    .cbs_o(cbs),
    .ebs_o(ebs)
  );

  // ----------------------------------------------------------------
  // Metering lookup
  // ----------------------------------------------------------------
  // Reserved mode maps nothing, so the rate reads zero and valid stays low
  assign look_map = map_index(meter_mode, meter_port_i, meter_prio_i);
  assign next_byte_time = ({6'h00, look_rate} + BYTE_TIME_OFFSET) * BYTE_TIME_UNIT_NS;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      look_valid_q <= 1'b0;
      meter_index_valid_o <= 1'b0;
      meter_rate_o <= RST_DATA;
      meter_byte_time_ns_o <= '0;
      meter_enable_o <= 1'b0;
      meter_mode_o <= MODE_PORT_PRIO;
    end else begin
      look_valid_q <= look_map[CIR_IDX_W];
      meter_index_valid_o <= look_valid_q;
      meter_rate_o <= look_rate;
      meter_byte_time_ns_o <= next_byte_time;
      meter_enable_o <= meter_en;
      meter_mode_o <= meter_mode;
    end
  end

  // ----------------------------------------------------------------
  // Burst sizes and bucket ceilings
  // ----------------------------------------------------------------
  // A lowered size only takes hold once the bucket level has drained to it;
  // a raised size takes hold at once since the level is then below it.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      committed_burst_o <= RST_BURST;
      excess_burst_o <= RST_BURST;
      committed_limit_o <= RST_BURST;
      excess_limit_o <= RST_BURST;
    end else begin
      committed_burst_o <= cbs;
      excess_burst_o <= ebs;
      if (committed_level_i <= cbs) begin
        committed_limit_o <= cbs;
      end
      if (excess_level_i <= ebs) begin
        excess_limit_o <= ebs;
      end
    end
  end

endmodule

// ---- irt_access_props.sv ----
// Purpose: Port-level checks for the rate table access block.
// Assumes: Bound to irt_access; one clock, synchronous reset.
// Notes: Limits are judged only when the burst copy is stable, so a fresh write is not misread.
`timescale 1ns/100ps
module irt_access_props import irt_pkg::*; (
  // Clock, reset and bus
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [BE_W-1:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // Metering side
  input wire logic [ENTRY_W-1:0] meter_rate_o,
  input wire logic [BYTE_TIME_W-1:0] meter_byte_time_ns_o,
  input wire logic meter_index_valid_o,
  input wire logic meter_enable_o,
  input wire logic [1:0] meter_mode_o,
  input wire logic [ENTRY_W-1:0] committed_level_i,
  input wire logic [ENTRY_W-1:0] excess_level_i,
  input wire logic [ENTRY_W-1:0] committed_burst_o,
  input wire logic [ENTRY_W-1:0] excess_burst_o,
  input wire logic [ENTRY_W-1:0] committed_limit_o,
  input wire logic [ENTRY_W-1:0] excess_limit_o
);
  // ----
  // Checks
  // ----
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire cfg_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == ADR_CFG;
  wire cfg_lane = cfg_wr && avs_byteenable_i[0];
  wire [1:0] wd_mode = avs_writedata_i[2:1];
  wire wd_en = avs_writedata_i[0];
  AST_ACCEPT: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("no answer");
  AST_ONE_LOW: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
  AST_IDLE_HIGH: assert property (
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o) else $error("answer without request");
  AST_RST_BURST: assert property (
    $fell(reset_i) |-> committed_burst_o == RST_BURST && excess_burst_o == RST_BURST
      && committed_limit_o == RST_BURST && excess_limit_o == RST_BURST) else $error("burst reset");
  AST_BYTE_TIME: assert property (
    meter_index_valid_o |-> meter_byte_time_ns_o ==
      ({6'h0, meter_rate_o} + BYTE_TIME_OFFSET) * BYTE_TIME_UNIT_NS) else $error("byte time");
  AST_CFG_COPY: assert property (
    cfg_lane |-> ##2 meter_mode_o == $past(wd_mode, 2) && meter_enable_o == $past(wd_en, 2))
    else $error("config copy");
  AST_CLIMIT: assert property (
    committed_level_i <= committed_burst_o ##1 $stable(committed_burst_o)
      |-> committed_limit_o == committed_burst_o) else $error("committed limit");
  AST_ELIMIT: assert property (
    excess_level_i > excess_burst_o ##1 $stable(excess_burst_o)
      |-> $stable(excess_limit_o)) else $error("excess limit");
  COV_VALID: cover property (meter_index_valid_o);
  COV_CFG: cover property (cfg_lane);
  COV_HOLD: cover property (excess_level_i > excess_burst_o);
endmodule
bind irt_access irt_access_props u_irt_access_props (.mclk_i(mclk_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .meter_rate_o(meter_rate_o),
  .meter_byte_time_ns_o(meter_byte_time_ns_o), .meter_index_valid_o(meter_index_valid_o),
  .meter_enable_o(meter_enable_o), .meter_mode_o(meter_mode_o),
  .committed_level_i(committed_level_i), .excess_level_i(excess_level_i),
  .committed_burst_o(committed_burst_o), .excess_burst_o(excess_burst_o),
  .committed_limit_o(committed_limit_o), .excess_limit_o(excess_limit_o));

// ---- irt_access_tb.sv ----
// Purpose: Self-checking bench for the rate table access block.
// Assumes: Bus answers one edge after acceptance.
// Notes: Lookup inputs are held four cycles, so pipeline depth cannot hide a wrong entry.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module irt_access_tb import irt_pkg::*;;
  logic mclk_i = 1'b0, reset_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic [DATA_W-1:0] avs_writedata_i = '0, avs_readdata_o, q, e32;
  logic [BE_W-1:0] avs_byteenable_i = 4'hf;
  logic avs_waitrequest_o, meter_index_valid_o, meter_enable_o;
  logic [1:0] meter_port_i = '0, meter_mode_o;
  logic [CIR_IDX_W-1:0] meter_prio_i = '0;
  logic [ENTRY_W-1:0] committed_level_i = '0, excess_level_i = '0, meter_rate_o;
  logic [ENTRY_W-1:0] committed_burst_o, excess_burst_o, committed_limit_o, excess_limit_o;
  logic [ENTRY_W-1:0] committed_rate_entry [CIR_COUNT];
  logic [ENTRY_W-1:0] cbs, ebs, last_rd, old;
  logic [BYTE_TIME_W-1:0] meter_byte_time_ns_o;
  logic [ADDR_W-1:0] ra [6] = '{ADR_CFG, ADR_CMD, ADR_STS, ADR_WDATA, ADR_RDATA, 16'h7ffc};
  int mismatches = 0, n_compared = 0;
  irt_access u_irt_access (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .meter_port_i(meter_port_i),
    .meter_prio_i(meter_prio_i), .meter_rate_o(meter_rate_o),
    .meter_byte_time_ns_o(meter_byte_time_ns_o), .meter_index_valid_o(meter_index_valid_o),
    .meter_enable_o(meter_enable_o), .meter_mode_o(meter_mode_o),
    .committed_level_i(committed_level_i), .excess_level_i(excess_level_i),
    .committed_burst_o(committed_burst_o), .excess_burst_o(excess_burst_o),
    .committed_limit_o(committed_limit_o), .excess_limit_o(excess_limit_o));
  // ----
  // Tasks
  // ----
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    avs_read_i <= !w;
    avs_write_i <= w;
    avs_address_i <= a;
    avs_writedata_i <= d;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  function automatic logic [ENTRY_W-1:0] ent(input logic [1:0] t, input logic [4:0] i);
    if (t == TBL_CIR) return (i < CIR_COUNT) ? committed_rate_entry[i] : 16'h0;
    if (t == TBL_CBS) return cbs;
    if (t == TBL_EBS) return ebs;
    return 16'h0;
  endfunction
  task automatic cmd(input logic read_not_write, input logic [1:0] t, input logic [4:0] i,
                     input logic [ENTRY_W-1:0] d);
    int n;
    if (!read_not_write) bus(1'b1, ADR_WDATA, {16'h0, d});
    bus(1'b1, ADR_CMD, {24'h0, read_not_write, t, i});
    bus(1'b0, ADR_STS, '0);
    `CHK("pending set", 1'b1, q[0])
    for (n = 0; n < 8 && q[0] !== 1'b0; n++) bus(1'b0, ADR_STS, '0);
    `CHK("pending clear", 1'b0, q[0])
    if (read_not_write) last_rd = ent(t, i);
    else if (t == TBL_CIR && i < CIR_COUNT) committed_rate_entry[i] = d;
    else if (t == TBL_CBS) cbs = d;
    else if (t == TBL_EBS) ebs = d;
    bus(1'b0, ADR_RDATA, '0);
    e32 = {16'h0, last_rd};
    `CHK("read staging", e32, q)
  endtask
  task automatic sweep(input logic read_not_write);
    for (int i = 0; i < 26; i++)
      cmd(read_not_write, i < 24 ? TBL_CIR : (i == 24 ? TBL_CBS : TBL_EBS), i[4:0], 16'($urandom));
  endtask
  function automatic int idx(input logic [1:0] m, input logic [1:0] p, input logic [4:0] r);
    if (m == MODE_PORT_PRIO && p < 3 && r < 8) return p * 8 + r;
    if (m == MODE_PORT && p < 3) return p;
    if (m == MODE_PRIO && r < 24) return r;
    return -1;
  endfunction
  task automatic look(input logic [1:0] m, input logic [1:0] p, input logic [4:0] r);
    int x;
    meter_port_i <= p;
    meter_prio_i <= r;
    repeat (4) @(posedge mclk_i);
    x = idx(m, p, r);
    `CHK("rate", x < 0 ? 16'h0 : committed_rate_entry[x], meter_rate_o)
    `CHK("valid", x >= 0, meter_index_valid_o)
    `CHK("mode", {1'b1, m}, {meter_enable_o, meter_mode_o})
    if (x >= 0) `CHK("byte", ({6'h0, committed_rate_entry[x]} + 22'h1) * 22'h14, meter_byte_time_ns_o)
  endtask
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (40000) @(posedge mclk_i);
    mismatches++;
    close_out();
  end
  initial begin
    void'($urandom(32'h9f12676d));
    foreach (committed_rate_entry[i]) committed_rate_entry[i] = RST_CIR;
    cbs = RST_BURST;
    ebs = RST_BURST;
    last_rd = 16'h0;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, ra[k], '0);
      `CHK("reg reset", 32'h0, q)
    end
    $display("test reset done");
    sweep(1'b1);
    sweep(1'b0);
    sweep(1'b1);
    $display("test table done");
    cmd(1'b0, TBL_RSVD, 5'h3, 16'($urandom));
    cmd(1'b1, TBL_RSVD, 5'h3, 16'h0);
    cmd(1'b0, TBL_CIR, 5'h18, 16'($urandom));
    cmd(1'b1, TBL_CIR, 5'h18, 16'h0);
    bus(1'b0, ADR_CMD, '0);
    `CHK("cmd readback", 32'h000000b8, q)
    avs_byteenable_i <= 4'h2;
    bus(1'b1, ADR_CMD, 32'h000000a0);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, ADR_STS, '0);
    `CHK("no launch", 32'h0, q)
    sweep(1'b1);
    $display("test reserved done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ADR_CFG, {29'h0, 2'(m), 1'b1});
      look(2'(m), 2'h2, 5'h7);
      look(2'(m), 2'h0, 5'h17);
      for (int k = 0; k < 10; k++) look(2'(m), 2'($urandom), 5'($urandom_range(0, 25)));
    end
    $display("test lookup done");
    cmd(1'b0, TBL_CBS, 5'h0, 16'h05ee);
    `CHK("committed burst", cbs, committed_burst_o)
    `CHK("committed limit", cbs, committed_limit_o)
    `CHK("excess burst", ebs, excess_burst_o)
    old = ebs;
    excess_level_i <= 16'hffff;
    cmd(1'b0, TBL_EBS, 5'h0, 16'h0100);
    `CHK("limit held", old, excess_limit_o)
    excess_level_i <= 16'h0;
    repeat (3) @(posedge mclk_i);
    `CHK("limit follows", 16'h0100, excess_limit_o)
    $display("test limit done");
    close_out();
  end
endmodule
